// ### hw/pab_backend.sv
`timescale 1ns/100ps
module pab_backend #(
    parameter int unsigned FIFO_DEPTH = pab_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic srst,
    input wire pab_pkg::pab_stage_set_t stage_in,
    output logic sample_phase,
    output logic hold_phase,
    output logic [pab_pkg::NUM_STAGES-1:0] stage_clk,
    output logic [pab_pkg::OUT_BITS-1:0] out_word,
    output logic out_valid,
    input wire logic out_ready,
    output logic [pab_pkg::OUT_BITS-1:0] fifo_word,
    output logic overflow
);
    import pab_pkg::*;

    // ------------------------------------------------------------
    // Phase generation
    // ------------------------------------------------------------
    // The master clock edge defines both phases; phase outputs are
    // registered from one toggle register and switch on the same edge, so
    // outside reset they are complementary and leave no gap between them.
    pab_phase_t phase_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_reg <= PAB_PH_SAMPLE;
        end else begin
            phase_reg <= (phase_reg == PAB_PH_SAMPLE) ? PAB_PH_HOLD : PAB_PH_SAMPLE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sample_phase <= 1'b0;
            hold_phase <= 1'b0;
        end else begin
            sample_phase <= (phase_reg == PAB_PH_HOLD);
            hold_phase <= (phase_reg == PAB_PH_SAMPLE);
        end
    end

    // Alternate stages run in opposite phase, so outside reset neighbours
    // always do the opposite job.
    genvar gs;
    generate
        for (gs = 0; gs < NUM_STAGES; gs++) begin : g_stage_clk
            if (gs % 2 == 0) begin : g_even
                assign stage_clk[gs] = sample_phase;
            end else begin : g_odd
                assign stage_clk[gs] = hold_phase;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Sample capture
    // ------------------------------------------------------------
    // Stage words arrive one per clock; all are registered on every clock
    // edge whatever the phase, i.e. stage k is taken k cycles after S/H.
    pab_stage_set_t cap_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            cap_reg <= '0;
        end else begin
            cap_reg <= stage_in;
        end
    end

    // ------------------------------------------------------------
    // Alignment delay line
    // ------------------------------------------------------------
    // Stage k's word for a sample appears k cycles later than stage 0,
    // so stage k is delayed by (NUM_STAGES-k) cycles to line up.
    pab_stage_word_t dly_reg [NUM_STAGES][NUM_STAGES];
    logic [RAW_BITS-1:0] aligned;

    genvar gk;
    generate
        for (gk = 0; gk < NUM_STAGES; gk++) begin : g_dly
            always_ff @(posedge clk) begin
                if (srst) begin
                    for (int i = 0; i < NUM_STAGES; i++) begin
                        dly_reg[gk][i] <= '0;
                    end
                end else begin
                    dly_reg[gk][0] <= cap_reg.word[gk];
                    for (int i = 1; i < NUM_STAGES; i++) begin
                        dly_reg[gk][i] <= dly_reg[gk][i-1];
                    end
                end
            end
            assign aligned[gk*STAGE_BITS +: STAGE_BITS] = dly_reg[gk][NUM_STAGES-1-gk];
        end
    endgenerate

    // ------------------------------------------------------------
    // Error correction
    // ------------------------------------------------------------
    // Full stages overlap each other by one bit: each full-stage word is
    // added at a 3-bit step (the last word 2 bits lower), so the redundant bit
    // absorbs comparator error from the stage before. Result is then clamped to range.
    function automatic logic [OUT_BITS-1:0] pab_correct(input logic [RAW_BITS-1:0] raw);
        logic [OUT_BITS+1:0] acc;
        acc = '0;
        for (int k = 0; k < NUM_FULL_STAGES; k++) begin
            acc = acc + ((OUT_BITS+2)'(raw[k*STAGE_BITS +: STAGE_BITS])
                << (STAGE_STEP*(NUM_FULL_STAGES-k) - 1));
        end
        acc = acc + (OUT_BITS+2)'(raw[NUM_FULL_STAGES*STAGE_BITS +: STAGE_BITS] >> LAST_SHIFT);
        if (acc[OUT_BITS+1:OUT_BITS] != 2'b00) begin
            // Saturate to the top offset-binary code.
            pab_correct = {OUT_BITS{1'b1}};
        end else begin
            pab_correct = acc[OUT_BITS-1:0];
        end
    endfunction : pab_correct

    // ------------------------------------------------------------
    // Output latch
    // ------------------------------------------------------------
    // Offset binary to two's complement is a flip of the top bit,
    // which maps the extremes onto the documented full-scale codes.
    logic [OUT_BITS-1:0] corrected;
    assign corrected = pab_correct(aligned) ^ MSB_FLIP;

    always_ff @(posedge clk) begin
        if (srst) begin
            out_word <= '0;
        end else begin
            out_word <= corrected;
        end
    end

    // The 4-cycle fill holds back only the first 4 words; the 3 after it still carry reset zeros and are not real samples.
    logic [2:0] fill_reg;
    logic primed;
    assign primed = (fill_reg == 3'(LATENCY_CYCLES));

    always_ff @(posedge clk) begin
        if (srst) begin
            fill_reg <= '0;
        end else if (!primed) begin
            fill_reg <= fill_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Output buffering
    // ------------------------------------------------------------
    // The converter cannot pause, so a full FIFO drops the word and
    // raises a sticky overflow instead of stalling the pipeline.
    logic fifo_in_ready;

    pab_fifo #(
        .WIDTH(OUT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(primed),
        .in_ready(fifo_in_ready),
        .in_data(out_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_word)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            overflow <= 1'b0;
        end else if (primed && !fifo_in_ready) begin
            overflow <= 1'b1;
        end
    end

endmodule : pab_backend

// ### hw/pab_fifo.sv
`timescale 1ns/100ps
module pab_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : pab_fifo

// ### hw/pab_pkg.sv
package pab_pkg;

    // ------------------------------------------------------------
    // Converter geometry
    // ------------------------------------------------------------
    localparam int unsigned STAGE_BITS = 4;
    localparam int unsigned NUM_FULL_STAGES = 4;
    localparam int unsigned NUM_STAGES = 5;
    localparam int unsigned RAW_BITS = 20;
    localparam int unsigned OUT_BITS = 14;
    localparam int unsigned LATENCY_CYCLES = 4;
    localparam int unsigned FIFO_DEPTH_DEF = 32;

    // Each full stage resolves three bits; weight step between stages.
    localparam int unsigned STAGE_STEP = 3;
    localparam int unsigned LAST_SHIFT = 0;

    localparam logic [OUT_BITS-1:0] CODE_POS_FS = 14'h1fff;
    localparam logic [OUT_BITS-1:0] CODE_NEG_FS = 14'h2000;
    localparam logic [OUT_BITS-1:0] MSB_FLIP = 14'h2000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [STAGE_BITS-1:0] pab_stage_word_t;

    typedef struct packed {
        pab_stage_word_t [NUM_STAGES-1:0] word;
    } pab_stage_set_t;

    typedef enum logic [0:0] {
        PAB_PH_SAMPLE = 1'b0,
        PAB_PH_HOLD = 1'b1
    } pab_phase_t;

endpackage : pab_pkg

// ### testbench/pab_backend_test.sv
`timescale 1ns/100ps
module pab_backend_test;
    import pab_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    pab_stage_set_t stage_in = '0;
    logic [1:0] mode = 2'd0;
    logic sample_phase, hold_phase, out_valid, out_ready, overflow, got, fifo_chk = 1'b0;
    logic [NUM_STAGES-1:0] stage_clk;
    logic [OUT_BITS-1:0] out_word, fifo_word, got_word, fill_word;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    pab_stage_set_t hist[$];
    always #2 clk = ~clk;
    pab_backend u_pab_backend (.clk(clk), .srst(srst), .stage_in(stage_in),
        .sample_phase(sample_phase), .hold_phase(hold_phase), .stage_clk(stage_clk),
        .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready),
        .fifo_word(fifo_word), .overflow(overflow));
    pab_sink u_pab_sink (.clk(clk), .mode(mode), .out_valid(out_valid),
        .fifo_word(fifo_word), .out_ready(out_ready), .got(got), .got_word(got_word));
    // ------
    // Model
    // ------
    task automatic cmp(string what, logic [OUT_BITS-1:0] exp, logic [OUT_BITS-1:0] seen);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    function automatic logic [OUT_BITS-1:0] model();
        int v = 0;
        int b = hist.size() - 7;
        for (int k = 0; k < 4; k++) begin
            v += int'(hist[b + k].word[k]) << (11 - 3 * k);
        end
        v += int'(hist[b + 4].word[4]);
        if (v > 16383)
            v = 16383;
        return OUT_BITS'(v) ^ 14'h2000;
    endfunction : model
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        if (srst) hist.delete();
        else hist.push_back(stage_in);
        cyc++;
        if (cyc > 2000) begin
            errors++;
            close_out();
        end
    end
    // Words before the pipeline has filled carry no sample and are skipped.
    always @(negedge clk) begin
        if (hist.size() >= 7) cmp("out_word", model(), out_word);
        if (got && fifo_chk) cmp("fifo_word", fill_word, got_word);
    end
    // ------
    // Tests
    // ------
    initial begin
        void'($urandom(32'hf12a));
        repeat (4) @(negedge clk);
        cmp("reset outputs", 14'h0, {out_word[13:2], out_valid, overflow});
        srst = 1'b0;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            stage_in = pab_stage_set_t'(i < 200 ? 20'($urandom) : (i < 250 ? 20'hfffff : 20'h0));
        end
        $display("test stream done");
        stage_in = pab_stage_set_t'(20'h11111);
        repeat (20) @(negedge clk);
        fill_word = model();
        fifo_chk = 1'b1;
        mode = 2'd1;
        repeat (40) @(negedge clk);
        cmp("overflow", 14'h3, {12'h0, overflow, out_valid});
        mode = 2'd2;
        repeat (100) @(negedge clk);
        cmp("overflow", 14'h1, {13'h0, overflow});
        $display("test fifo done");
        fifo_chk = 1'b0;
        srst = 1'b1;
        @(negedge clk);
        cmp("reset outputs", 14'h0, {12'h0, out_valid, overflow});
        srst = 1'b0;
        for (int i = 0; i < 30; i++) begin
            @(negedge clk);
            stage_in = pab_stage_set_t'(20'($urandom));
        end
        $display("test reset done");
        close_out();
    end
endmodule : pab_backend_test
bind pab_backend pab_props u_pab_props (.clk(clk), .srst(srst), .stage_in(stage_in),
    .sample_phase(sample_phase), .hold_phase(hold_phase), .stage_clk(stage_clk),
    .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready),
    .fifo_word(fifo_word), .overflow(overflow));

// ### testbench/pab_props.sv
`timescale 1ns/100ps
module pab_props (
    input wire logic clk,
    input wire logic srst,
    input wire pab_pkg::pab_stage_set_t stage_in,
    input wire logic sample_phase,
    input wire logic hold_phase,
    input wire logic [pab_pkg::NUM_STAGES-1:0] stage_clk,
    input wire logic [pab_pkg::OUT_BITS-1:0] out_word,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [pab_pkg::OUT_BITS-1:0] fifo_word,
    input wire logic overflow
);
    import pab_pkg::*;
    // ------
    // Checks
    // ------
    // Counts clean cycles so lagged inputs never reach back into a reset.
    logic [3:0] run_reg;
    always_ff @(posedge clk) begin
        if (srst) run_reg <= 4'h0;
        else if (run_reg != 4'hf) run_reg <= run_reg + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_excl; !(sample_phase && hold_phase); endproperty
    a_excl: assert property (p_excl) else $error("phases overlap");
    property p_comp; !$past(srst) |-> sample_phase != hold_phase; endproperty
    a_comp: assert property (p_comp) else $error("phases not complementary");
    property p_alt; hold_phase |=> sample_phase ##1 hold_phase; endproperty
    a_alt: assert property (p_alt) else $error("hold not followed by sample");
    property p_stclk; !$past(srst) |-> stage_clk == (sample_phase ? 5'h15 : 5'h0a); endproperty
    a_stclk: assert property (p_stclk) else $error("stage clocks not staggered");
    property p_pos; run_reg > 4'h8 && $past(stage_in.word[0], 7) == 4'hf |-> out_word == 14'h1fff;
    endproperty
    a_pos: assert property (p_pos) else $error("positive full scale wrong");
    property p_neg; run_reg > 4'h8 && $past(stage_in.word[0], 7) == 4'h0
        && $past(stage_in.word[1], 6) == 4'h0 && $past(stage_in.word[2], 5) == 4'h0
        && $past(stage_in.word[3], 4) == 4'h0 && $past(stage_in.word[4], 3) == 4'h0
        |-> out_word == 14'h2000; endproperty
    a_neg: assert property (p_neg) else $error("negative full scale wrong");
    property p_rst; $past(srst) |-> !out_valid && !overflow && out_word == 14'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(fifo_word); endproperty
    a_hold: assert property (p_hold) else $error("head word lost while stalled");
    property p_ovf; overflow |=> overflow; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not sticky");
endmodule : pab_props

// ### testbench/pab_sink.sv
`timescale 1ns/100ps
module pab_sink (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic out_valid,
    input wire logic [pab_pkg::OUT_BITS-1:0] fifo_word,
    output logic out_ready,
    output logic got,
    output logic [pab_pkg::OUT_BITS-1:0] got_word
);
    import pab_pkg::*;
    // Mode 0 always takes, 1 stalls, 2 takes at random.
    initial out_ready = 1'b0;
    always @(negedge clk) begin
        out_ready <= mode == 2'd0 || (mode == 2'd2 && $urandom_range(1) == 1);
    end
    always @(posedge clk) begin
        got <= out_valid && out_ready;
        got_word <= fifo_word;
    end
endmodule : pab_sink
